// ==== include/timer_pkg.sv ====
// constants and state layout of the 8-bit waveform timer
// Summary of operation
// - only mode select shapes counting; output action never changes it
// - normal mode always counts up, no match clear, wraps FF to 00
// - normal mode sets overflow flag as counter becomes zero
// - normal mode accepts a counter write at any moment
// - clear-on-compare mode clears counter when it equals compare value
// - clear-on-compare compare value is unbuffered; low writes wrap first
// - clear-on-compare raises match flag each time top is reached
// - clear-on-compare action 1 toggles output on every match
// - clear-on-compare sets overflow flag passing max to zero
// - timer tick is clock divided by 1,8,32,64,128,256 or 1024
// - fast mode counts bottom to max, clears tick after max
// - fast mode sets overflow flag every time max is reached
// - fast action 2 clears on match, sets at wrap; 3 inverse
// - fast compare bottom gives spike, compare max gives steady level
// - fast action 1 toggles on each match, compare double buffered
// - fast mode output period is 256 ticks with action 2 or 3, 512 ticks with toggle action 1
// - phase mode counts up then down, max held one tick
// - phase action 2 clears on up match, sets on down; 3 inverse
// - phase mode sets overflow flag each time bottom is reached
// - phase mode output period is 510 ticks
// - phase compare bottom holds low, max holds high; inverted opposite
// - output reaches pin only when direction bit selects output
// - pwm modes buffer compare to top; other modes apply at once
// - counter write blocks any compare match in next tick
// - equality sets compare match flag one tick later
// - clock source zero stops counting; counter stays accessible
package timer_pkg;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0C;

  // control word and flags register fields
  localparam int CTRL_MODE_LO  = 0;
  localparam int CTRL_ACT_LO   = 2;
  localparam int CTRL_CS_LO    = 4;
  localparam int CTRL_FORCE    = 7;
  localparam int CTRL_DIR      = 8;
  localparam int CTRL_PORT     = 9;
  localparam int FLAG_OVF      = 0;
  localparam int FLAG_CMP      = 1;
  localparam int FLAG_WAVE     = 2;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE  = 2'h1;
  localparam logic [1:0] MODE_CTC    = 2'h2;
  localparam logic [1:0] MODE_FAST   = 2'h3;

  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  localparam int         PRE_W      = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic             aw_rdy;
    logic             w_rdy;
    logic             ar_rdy;
    logic             bvalid;
    logic             rvalid;
    logic [1:0]       bresp;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             aw_full;
    logic             w_full;
    logic [7:0]       aw_addr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic [1:0]       mode;
    logic [1:0]       action;
    logic [2:0]       clk_sel;
    logic             dir_bit;
    logic             port_bit;
    logic [7:0]       cnt;
    logic [7:0]       ocr_buf;
    logic [7:0]       ocr;
    logic             up;
    logic             blk;
    logic             hit;
    logic             ovf;
    logic             cmf;
    logic             wave;
    logic [PRE_W-1:0] pre;
    logic             pin_out;
    logic             pin_oe;
  } timer_state_s;

endpackage

// ==== hdl/timer_waveform_modes_8bit.sv ====
// 8-bit timer with one compare channel, four waveform modes, AXI4-Lite
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module timer_waveform_modes_8bit
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address channel
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // write response channel
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read address channel
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // read data channel
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // flag acknowledge and flags
  input  wire logic        overflow_ack,
  input  wire logic        compare_ack,
  output logic             overflow_flag,
  output logic             compare_match_flag,
  // port pin
  output logic             wave_pin_out,
  output logic             wave_pin_oe
);

  timer_state_s s;
  timer_state_s n;

  logic       wr_go;
  logic       ctrl_we;
  logic       cnt_we;
  logic       ocr_we;
  logic       flg_we;
  logic       timer_tick;
  logic       eq;
  logic       match;
  logic       top_hit;
  logic       going_up;
  logic       set_ovf;
  logic       set_cmf;
  logic       clr_ovf;
  logic       clr_cmf;

  // register index from a byte address; bit 2 flags a mapped word
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    unique case (a)
      ADDR_CTRL:    reg_idx = 3'h4;
      ADDR_COUNT:   reg_idx = 3'h5;
      ADDR_COMPARE: reg_idx = 3'h6;
      ADDR_FLAGS:   reg_idx = 3'h7;
      default:      reg_idx = 3'h0;
    endcase
  endfunction

  // prescaler taps: 1, 8, 32, 64, 128, 256, 1024
  function automatic logic tick_on(input logic [2:0]       sel,
                                   input logic [PRE_W-1:0] p);
    unique case (sel)
      3'h0:    tick_on = 1'b0;
      3'h1:    tick_on = 1'b1;
      3'h2:    tick_on = &p[2:0];
      3'h3:    tick_on = &p[4:0];
      3'h4:    tick_on = &p[5:0];
      3'h5:    tick_on = &p[6:0];
      3'h6:    tick_on = &p[7:0];
      default: tick_on = &p[9:0];
    endcase
  endfunction

  // non-pwm output action on a match or forced match
  function automatic logic act_apply(input logic [1:0] act,
                                     input logic       w);
    unique case (act)
      2'h0: act_apply = w;
      2'h1: act_apply = ~w;
      2'h2: act_apply = 1'b0;
      2'h3: act_apply = 1'b1;
    endcase
  endfunction

  always_comb begin
    n = s;
    // write address and data taken in either order
    if (awvalid && s.aw_rdy) begin
      n.aw_full = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.w_rdy) begin
      n.w_full = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    wr_go = s.aw_full && s.w_full && !s.bvalid;
    if (bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = (reg_idx(s.aw_addr) >= 3'h4) ? RESP_OKAY : RESP_SLVERR;
    end
    n.aw_rdy = !n.aw_full && !n.bvalid;
    n.w_rdy  = !n.w_full && !n.bvalid;
    ctrl_we = wr_go && s.wstrb[0] && reg_idx(s.aw_addr) == 3'h4;
    cnt_we  = wr_go && s.wstrb[0] && reg_idx(s.aw_addr) == 3'h5;
    ocr_we  = wr_go && s.wstrb[0] && reg_idx(s.aw_addr) == 3'h6;
    flg_we  = wr_go && s.wstrb[0] && reg_idx(s.aw_addr) == 3'h7;

    // read channel: one read in flight, answered the next cycle
    if (rvalid && rready) begin
      n.rvalid = 1'b0;
      n.ar_rdy = 1'b1;
    end
    if (arvalid && s.ar_rdy) begin
      n.ar_rdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp  = (reg_idx(araddr) >= 3'h4) ? RESP_OKAY : RESP_SLVERR;
      n.rdata  = 32'h0000_0000;
      unique case (reg_idx(araddr))
        3'h4: begin
          n.rdata[CTRL_MODE_LO +: 2] = s.mode;
          n.rdata[CTRL_ACT_LO +: 2]  = s.action;
          n.rdata[CTRL_CS_LO +: 3]   = s.clk_sel;
          n.rdata[CTRL_DIR]          = s.dir_bit;
          n.rdata[CTRL_PORT]         = s.port_bit;
        end
        3'h5: n.rdata[7:0] = s.cnt;
        3'h6: n.rdata[7:0] = s.ocr_buf;
        3'h7: begin
          n.rdata[FLAG_OVF]  = s.ovf;
          n.rdata[FLAG_CMP]  = s.cmf;
          n.rdata[FLAG_WAVE] = s.wave;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    n.pre      = s.pre + 1'b1;
    timer_tick = tick_on(s.clk_sel, s.pre);

    eq      = s.cnt == s.ocr;
    match   = eq && !s.blk;
    top_hit = s.cnt == CNT_MAX;
    // direction turns at max and at bottom
    going_up = (s.mode == MODE_PHASE)
             ? (s.up ? !top_hit : s.cnt == CNT_BOTTOM)
             : 1'b1;
    set_ovf = 1'b0;
    set_cmf = 1'b0;

    if (timer_tick) begin
      n.blk = 1'b0;
      n.hit = match;
      // flag follows equality by one tick
      set_cmf = s.hit;
      // only the mode select picks the sequence
      unique case (s.mode)
        MODE_NORMAL: begin
          n.cnt = s.cnt + CNT_ONE;
          set_ovf = top_hit;
          if (match) begin
            n.wave = act_apply(s.action, s.wave);
          end
        end
        MODE_CTC: begin
          // clear on match; else run on and wrap
          n.cnt = match ? CNT_BOTTOM : s.cnt + CNT_ONE;
          set_ovf = top_hit;
          if (match) begin
            n.wave = act_apply(s.action, s.wave);
          end
        end
        MODE_FAST: begin
          n.cnt = s.cnt + CNT_ONE;
          set_ovf = top_hit;
          if (top_hit) begin
            n.ocr = s.ocr_buf;
          end
          // set or clear at wrap, inverse on match
          // max compare ignored, bottom compare spikes
          if (s.action[1]) begin
            if (top_hit) begin
              n.wave = ~s.action[0];
            end else if (match && s.ocr != CNT_MAX) begin
              n.wave = s.action[0];
            end
          end else if (s.action[0] && match) begin
            n.wave = ~s.wave;
          end
        end
        MODE_PHASE: begin
          n.cnt = going_up ? s.cnt + CNT_ONE : s.cnt - CNT_ONE;
          n.up  = going_up;
          set_ovf = !going_up && s.cnt == CNT_ONE;
          if (top_hit) begin
            n.ocr = s.ocr_buf;
          end
          // up match and down match act oppositely
          // max compare resolved at top for steady level
          if (s.action[1]) begin
            if (match && s.ocr != CNT_MAX) begin
              n.wave = going_up ? s.action[0] : ~s.action[0];
            end else if (top_hit && s.ocr == CNT_MAX) begin
              n.wave = ~s.action[0];
            end
          end
        end
      endcase
    end

    // forced match only in non-pwm modes, no flag and no clear
    if (ctrl_we) begin
      n.mode     = s.wdata[CTRL_MODE_LO +: 2];
      n.action   = s.wdata[CTRL_ACT_LO +: 2];
      n.clk_sel  = s.wdata[CTRL_CS_LO +: 3];
      if (s.wdata[CTRL_FORCE] && !s.mode[0]) begin
        n.wave = act_apply(s.wdata[CTRL_ACT_LO +: 2], s.wave);
      end
    end
    if (wr_go && s.wstrb[1] && reg_idx(s.aw_addr) == 3'h4) begin
      n.dir_bit  = s.wdata[CTRL_DIR];
      n.port_bit = s.wdata[CTRL_PORT];
    end
    if (cnt_we) begin
      n.cnt = s.wdata[7:0];
      n.blk = 1'b1;
    end
    if (ocr_we) begin
      n.ocr_buf = s.wdata[7:0];
      if (!s.mode[0]) begin
        n.ocr = s.wdata[7:0];
      end
    end

    // flags held until ack or write one; set wins
    clr_ovf = overflow_ack || (flg_we && s.wdata[FLAG_OVF]);
    clr_cmf = compare_ack || (flg_we && s.wdata[FLAG_CMP]);
    n.ovf   = (s.ovf && !clr_ovf) || set_ovf;
    n.cmf   = (s.cmf && !clr_cmf) || set_cmf;

    // pin driven only with direction set
    n.pin_oe  = n.dir_bit;
    n.pin_out = (n.action != 2'h0) ? n.wave : n.port_bit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s        <= '0;
      s.aw_rdy <= 1'b1;
      s.w_rdy  <= 1'b1;
      s.ar_rdy <= 1'b1;
      s.up     <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign awready            = s.aw_rdy;
  assign wready             = s.w_rdy;
  assign arready            = s.ar_rdy;
  assign bvalid             = s.bvalid;
  assign bresp              = s.bresp;
  assign rvalid             = s.rvalid;
  assign rresp              = s.rresp;
  assign rdata              = s.rdata;
  assign overflow_flag      = s.ovf;
  assign compare_match_flag = s.cmf;
  assign wave_pin_out       = s.pin_out;
  assign wave_pin_oe        = s.pin_oe;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_normal_wrap: assert property (
    s.mode == MODE_NORMAL && timer_tick && !cnt_we && top_hit
    |=> s.cnt == CNT_BOTTOM)
    else $error("normal mode did not wrap to zero");
  chk_normal_ovf: assert property (
    s.mode == MODE_NORMAL && timer_tick && top_hit |=> s.ovf)
    else $error("overflow flag missing at wrap");
  chk_ctc_clear: assert property (
    s.mode == MODE_CTC && timer_tick && match && !cnt_we
    |=> s.cnt == CNT_BOTTOM)
    else $error("ctc counter not cleared on match");
  chk_match_flag: assert property (
    timer_tick && s.hit |=> s.cmf)
    else $error("compare flag not set one tick late");
  chk_write_block: assert property (
    cnt_we ##1 timer_tick |=> !s.hit)
    else $error("match seen after counter write");
  chk_fast_wrap: assert property (
    s.mode == MODE_FAST && timer_tick && top_hit && !cnt_we
    |=> s.cnt == CNT_BOTTOM && s.ovf)
    else $error("fast mode wrap wrong");
  chk_phase_turn: assert property (
    s.mode == MODE_PHASE && timer_tick && top_hit && !cnt_we
    |=> s.cnt == 8'hFE && !s.up)
    else $error("phase mode did not turn at max");
  chk_phase_ovf: assert property (
    s.mode == MODE_PHASE && timer_tick && !going_up && !cnt_we
    && s.cnt == CNT_ONE |=> s.ovf && s.cnt == CNT_BOTTOM)
    else $error("phase mode bottom flag missing");
  chk_fast_set: assert property (
    s.mode == MODE_FAST && s.action == 2'h2 && timer_tick
    && top_hit && !ctrl_we |=> s.wave)
    else $error("fast output not set at wrap");
  chk_pin_dir: assert property (
    wave_pin_oe == s.dir_bit)
    else $error("pin enable not following direction");
  chk_flag_hold: assert property (
    s.ovf && !overflow_ack && !flg_we |=> s.ovf)
    else $error("overflow flag dropped on its own");

  chk_ctc_wrap: assert property (
    s.mode == MODE_CTC && timer_tick && top_hit && !cnt_we
    |=> s.cnt == CNT_BOTTOM)
    else $error("ctc counter did not wrap past max");
  chk_ctc_ovf: assert property (
    s.mode == MODE_CTC && timer_tick && top_hit |=> s.ovf)
    else $error("ctc overflow flag missing at wrap");
  chk_ctc_toggle: assert property (
    s.mode == MODE_CTC && s.action == 2'h1 && timer_tick && match
    && !ctrl_we |=> s.wave != $past(s.wave))
    else $error("ctc output did not toggle on match");
  chk_fast_clear: assert property (
    s.mode == MODE_FAST && s.action == 2'h2 && timer_tick && match
    && !top_hit && s.ocr != CNT_MAX |=> !s.wave)
    else $error("fast output not cleared on match");
  chk_phase_up: assert property (
    s.mode == MODE_PHASE && s.action == 2'h2 && timer_tick && match
    && going_up && s.ocr != CNT_MAX |=> !s.wave)
    else $error("phase output not cleared on up match");
  chk_phase_down: assert property (
    s.mode == MODE_PHASE && s.action == 2'h2 && timer_tick && match
    && !going_up && s.ocr != CNT_MAX |=> s.wave)
    else $error("phase output not set on down match");
  chk_stop_hold: assert property (
    s.clk_sel == 3'h0 && !cnt_we |=> $stable(s.cnt))
    else $error("counter moved with clock source off");
  chk_pwm_buffer: assert property (
    s.mode[0] && ocr_we && !(timer_tick && top_hit) |=> $stable(s.ocr))
    else $error("pwm compare changed before top");
  chk_cmp_hold: assert property (
    s.cmf && !compare_ack && !flg_we |=> s.cmf)
    else $error("compare flag dropped on its own");

endmodule // timer_waveform_modes_8bit

// ==== verification/pin_load_model.sv ====
// outside circuitry on the waveform pin: resolves the wire level
`timescale 1ns/1ps
module pin_load_model (
  // drive from the timer
  input  wire logic drive,
  input  wire logic oe,
  // level seen on the wire
  output logic      level
);
  // pin follows drive only while enabled
  // no pull on this net, so a released pin shows the opposite level
  assign level = oe ? drive : ~drive;
endmodule // pin_load_model

// ==== verification/timer_waveform_modes_8bit_test.sv ====
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
module timer_waveform_modes_8bit_test import timer_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        overflow_ack = 1'h0, compare_ack = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        overflow_flag, compare_match_flag;
  logic        wave_pin_out, wave_pin_oe, pin_level;
  int          miscompares = 0, samples_checked = 0, cycles = 0;

  timer_waveform_modes_8bit uut (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .overflow_ack, .compare_ack, .overflow_flag, .compare_match_flag,
    .wave_pin_out, .wave_pin_oe
  );
  pin_load_model load (
    .drive(wave_pin_out),
    .oe   (wave_pin_oe),
    .level(pin_level)
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  task print_verdict;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // the whole run needs about 50k cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      print_verdict();
    end
  end

  task check(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    ad = 1'h0;
    wd = 1'h0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'h1) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (!wd && wready === 1'h1) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1) @(posedge aclk);
    bready <= 1'h0;
    check("write resp", 32'(er), 32'(bresp));
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge aclk);
    rready <= 1'h0;
    check("read data", e, rdata);
    check("read resp", 32'(er), 32'(rresp));
  endtask

  task cfg(input logic [1:0] m, a, input logic [2:0] cs, input logic [7:0] c);
    wr(ADDR_COMPARE, {24'h0, c}, RESP_OKAY);
    wr(ADDR_CTRL, {22'h0, 2'h1, 1'h0, cs, a, m}, RESP_OKAY);
  endtask

  // waits for a flag, then acknowledges it with a one-cycle pulse
  task wait_set(input logic cmp, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while ((cmp ? compare_match_flag : overflow_flag) !== 1'h1 && n < 10000);
    overflow_ack <= !cmp;
    compare_ack <= cmp;
    @(posedge aclk);
    overflow_ack <= 1'h0;
    compare_ack <= 1'h0;
  endtask

  // first two waits may see a stale flag or a partial period
  task per_chk(input string nm, input logic cmp, input int p);
    int n;
    repeat (3) wait_set(cmp, n);
    check(nm, 32'(p), 32'(n + 1));
  endtask

  task pin_meas(output int p, output int hi);
    logic prev;
    int   k;
    p = 0;
    hi = 0;
    k = 0;
    do begin
      prev = pin_level;
      @(posedge aclk);
      k++;
    end while (!(pin_level === 1'h1 && prev === 1'h0) && k < 3000);
    do begin
      hi += int'(pin_level === 1'h1);
      prev = pin_level;
      @(posedge aclk);
      p++;
    end while (!(pin_level === 1'h1 && prev === 1'h0) && p < 3000);
  endtask

  task wave(input logic [1:0] m, a, input logic [7:0] c, input int p, hi);
    int mp, mh;
    cfg(m, a, 3'h1, c);
    repeat (600) @(posedge aclk);
    pin_meas(mp, mh);
    check("pin period", 32'(p), 32'(mp));
    check("pin high", 32'(hi), 32'(mh));
  endtask

  task hold(input logic [1:0] m, a, input logic [7:0] c, input logic v);
    int bad;
    bad = 0;
    cfg(m, a, 3'h1, c);
    // a pwm compare at an extreme may need two tops before it settles
    repeat (1100) @(posedge aclk);
    repeat (600) begin
      @(posedge aclk);
      if (pin_level !== v) bad++;
    end
    check("pin steady", 32'h0, 32'(bad));
  endtask

  task t_reset;
    for (int i = 0; i < 4; i++) rdc(8'(4 * i), 32'h0, RESP_OKAY);
    rdc(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h0000_0011, RESP_SLVERR);
    rdc(ADDR_CTRL, 32'h0, RESP_OKAY);
    check("pin oe", 32'h0, 32'(wave_pin_oe));
  endtask

  task t_pin;
    wr(ADDR_CTRL, 32'h0000_0200, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("pin oe", 32'h0, 32'(wave_pin_oe));
    check("pin level", 32'h0, 32'(pin_level));
    wr(ADDR_CTRL, 32'h0000_0300, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("pin level", 32'h1, 32'(pin_level));
    // forced match: set, then clear, with the timer stopped
    wr(ADDR_CTRL, 32'h0000_038C, RESP_OKAY);
    rdc(ADDR_FLAGS, 32'h0000_0004, RESP_OKAY);
    rdc(ADDR_CTRL, 32'h0000_030C, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0388, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("pin level", 32'h0, 32'(pin_level));
  endtask

  task t_stopped;
    wr(ADDR_COMPARE, 32'h0000_0020, RESP_OKAY);
    wr(ADDR_COUNT, 32'h0000_0020, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rdc(ADDR_COUNT, 32'h0000_0020, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0010, RESP_OKAY);
    repeat (100) @(posedge aclk);
    check("match flag", 32'h0, 32'(compare_match_flag));
    per_chk("normal match", 1'h1, 256);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    check("overflow flag", 32'h1, 32'(overflow_flag));
    wr(ADDR_FLAGS, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("overflow flag", 32'h0, 32'(overflow_flag));
  endtask

  task t_normal;
    int np [3];
    np = '{256, 2048, 8192};
    for (int i = 1; i < 4; i++) begin
      cfg(MODE_NORMAL, 2'h0, 3'(i), 8'h00);
      per_chk("overflow period", 1'h0, np[i-1]);
    end
  endtask

  task t_ctc;
    cfg(MODE_CTC, 2'h1, 3'h1, 8'h04);
    per_chk("ctc match", 1'h1, 5);
    wave(MODE_CTC, 2'h1, 8'h04, 10, 5);
    cfg(MODE_CTC, 2'h3, 3'h1, 8'h04);
    per_chk("ctc match", 1'h1, 5);
  endtask

  task t_fast;
    cfg(MODE_FAST, 2'h2, 3'h1, 8'h40);
    per_chk("fast overflow", 1'h0, 256);
    wave(MODE_FAST, 2'h2, 8'h40, 256, 65);
    wave(MODE_FAST, 2'h3, 8'h40, 256, 191);
    wave(MODE_FAST, 2'h2, 8'h00, 256, 1);
    wave(MODE_FAST, 2'h1, 8'h40, 512, 256);
    hold(MODE_FAST, 2'h2, 8'hFF, 1'h1);
  endtask

  task t_phase;
    cfg(MODE_PHASE, 2'h2, 3'h1, 8'h40);
    per_chk("phase overflow", 1'h0, 510);
    wave(MODE_PHASE, 2'h2, 8'h40, 510, 128);
    wave(MODE_PHASE, 2'h3, 8'h40, 510, 382);
    hold(MODE_PHASE, 2'h2, 8'h00, 1'h0);
    hold(MODE_PHASE, 2'h2, 8'hFF, 1'h1);
    hold(MODE_PHASE, 2'h3, 8'h00, 1'h1);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_pin();
    t_stopped();
    t_normal();
    t_ctc();
    t_fast();
    t_phase();
    print_verdict();
  end
endmodule // timer_waveform_modes_8bit_test
